// ==== hw/secondary_cell_minmax_monitor.sv ====
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "minmax_defs.svh"


module secondary_cell_minmax_monitor #(
  // Post-window averaging interval in clock cycles
  parameter int AVE_CYCLES = `MM_T_AVE_NS / `MM_CLK_NS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Comparators: cell above the trial code, one bit per channel
  input wire logic [`MM_CELLS-1:0] cmp_above_hi,
  input wire logic [`MM_CELLS-1:0] cmp_above_lo,
  // Trial codes to the comparator references
  output logic [`MM_CODE_W-1:0] dac_hi_code,
  output logic [`MM_CODE_W-1:0] dac_lo_code,
  // Status
  output logic busy
);

  // ----------------------------------------------------------------
  // Derived timing
  // ----------------------------------------------------------------
  localparam int SAMPLE_CYCLES = `MM_ADC_DIV * `MM_ADC_CLK_NS / `MM_CLK_NS;
  localparam int MEAS_SAMPLES = 1 << `MM_SMP_LOG2;
  localparam logic [`MM_PER_CNT_W-1:0] PER_LAST = `MM_PER_CNT_W'(SAMPLE_CYCLES - 1);
  localparam logic [`MM_SMP_CNT_W-1:0] SMP_LAST = `MM_SMP_CNT_W'(MEAS_SAMPLES);
  localparam logic [`MM_AVE_CNT_W-1:0] AVE_LAST = `MM_AVE_CNT_W'(AVE_CYCLES - 1);

  localparam minmax_pkg::mon_regs_t RST = '{
    st: minmax_pkg::ST_IDLE,
    mask: `MM_MASK_RST,
    part: `MM_PART_RST,
    default: '0
  };

  minmax_pkg::mon_regs_t r;
  minmax_pkg::mon_regs_t n;
  logic req;
  logic wr;
  logic [`MM_CELLS-1:0] armed;
  logic per_end;

  search_if sif ();

  // ----------------------------------------------------------------
  // Binary search engine
  // ----------------------------------------------------------------
  extreme_search u_search (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .sif(sif),
    .cmp_above_hi(cmp_above_hi),
    .cmp_above_lo(cmp_above_lo),
    .dac_hi_code(dac_hi_code),
    .dac_lo_code(dac_lo_code)
  );

  assign sif.start = r.go;
  assign sif.mask = r.eff;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.go = 1'b0;
    req = wb_cyc_i & wb_stb_i;
    // Writes take effect on the edge that shows ack to the master
    wr = req & wb_we_i & r.ack;
    // Cells not active in the partition are never searched
    armed = r.mask & r.part;
    per_end = (r.per_cnt == PER_LAST);

    // Bus handshake: ack one cycle after the request, then drop
    n.ack = req & ~r.ack;
    n.dat = '0;
    if (req & ~r.ack) begin
      unique case (wb_adr_i)
        `MM_OFS_CTRL: begin
          n.dat[`MM_CTRL_BUSY] = r.busy;
        end
        `MM_OFS_MASK: begin
          n.dat[`MM_CELLS-1:0] = r.mask;
        end
        `MM_OFS_PART: begin
          n.dat[`MM_CELLS-1:0] = r.part;
        end
        `MM_OFS_HI: begin
          n.dat[`MM_CODE_W-1:0] = r.res_hi;
          n.dat[`MM_UPD_LSB+1:`MM_UPD_LSB] = r.upd_hi;
        end
        `MM_OFS_LO: begin
          n.dat[`MM_CODE_W-1:0] = r.res_lo;
          n.dat[`MM_UPD_LSB+1:`MM_UPD_LSB] = r.upd_lo;
        end
        default: begin
          n.dat = '0;
        end
      endcase
    end

    // Configuration writes, byte lane by byte lane
    if (wr && wb_adr_i == `MM_OFS_MASK) begin
      if (wb_sel_i[0]) begin
        n.mask[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        n.mask[`MM_CELLS-1:8] = wb_dat_i[`MM_CELLS-1:8];
      end
    end
    if (wr && wb_adr_i == `MM_OFS_PART) begin
      if (wb_sel_i[0]) begin
        n.part[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        n.part[`MM_CELLS-1:8] = wb_dat_i[`MM_CELLS-1:8];
      end
    end

    // ----------------------------------------------------------------
    // Measurement sequence
    // ----------------------------------------------------------------
    unique case (r.st)
      minmax_pkg::ST_IDLE: begin
        // Start with no armed cell is dropped: nothing to search
        if (wr && wb_adr_i == `MM_OFS_CTRL && wb_sel_i[0] &&
            wb_dat_i[`MM_CTRL_START] && armed != '0) begin
          n.eff = armed;
          n.acc_hi = '0;
          n.acc_lo = '0;
          n.smp_cnt = '0;
          n.per_cnt = '0;
          n.go = 1'b1;
          n.busy = 1'b1;
          n.st = minmax_pkg::ST_SAMPLE;
        end
      end
      minmax_pkg::ST_SAMPLE: begin
        n.per_cnt = r.per_cnt + `MM_PER_CNT_W'(1);
        // Search (22 cycles) always fits inside one period
        if (sif.done) begin
          n.acc_hi = r.acc_hi + `MM_ACC_W'(sif.max_code);
          n.acc_lo = r.acc_lo + `MM_ACC_W'(sif.min_code);
          n.smp_cnt = r.smp_cnt + `MM_SMP_CNT_W'(1);
          n.st = minmax_pkg::ST_PACE;
        end
      end
      minmax_pkg::ST_PACE: begin
        n.per_cnt = r.per_cnt + `MM_PER_CNT_W'(1);
        if (per_end) begin
          n.per_cnt = '0;
          if (r.smp_cnt == SMP_LAST) begin
            n.ave_cnt = '0;
            n.st = minmax_pkg::ST_AVERAGE;
          end else begin
            n.go = 1'b1;
            n.st = minmax_pkg::ST_SAMPLE;
          end
        end
      end
      minmax_pkg::ST_AVERAGE: begin
        n.ave_cnt = r.ave_cnt + `MM_AVE_CNT_W'(1);
        if (r.ave_cnt == AVE_LAST) begin
          // Window is a power of two, so the mean is a shift
          n.res_hi = r.acc_hi[`MM_ACC_W-1:`MM_SMP_LOG2];
          n.res_lo = r.acc_lo[`MM_ACC_W-1:`MM_SMP_LOG2];
          n.upd_hi = r.upd_hi + 2'd1;
          n.upd_lo = r.upd_lo + 2'd1;
          n.busy = 1'b0;
          n.st = minmax_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  // No link to the main measurement: both may run at once
  assign busy = r.busy;
  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.dat;

endmodule : secondary_cell_minmax_monitor

// ==== hw/minmax_defs.svh ====
`ifndef MINMAX_DEFS_SVH
`define MINMAX_DEFS_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define MM_CELLS 12
`define MM_CODE_W 11
`define MM_IDX_W 4
`define MM_SMP_LOG2 4
`define MM_ACC_W 15
`define MM_SMP_CNT_W 5
`define MM_PER_CNT_W 16
`define MM_AVE_CNT_W 20

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
// Converter clocks per secondary sample
`define MM_ADC_DIV 64
`define MM_ADC_CLK_NS 10
`define MM_CLK_NS 10
`define MM_T_AVE_NS 298000

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define MM_OFS_CTRL 8'h00
`define MM_OFS_MASK 8'h04
`define MM_OFS_PART 8'h08
`define MM_OFS_HI 8'h0C
`define MM_OFS_LO 8'h10
`define MM_CTRL_START 0
`define MM_CTRL_BUSY 1
`define MM_UPD_LSB 12
`define MM_MASK_RST 12'h000
`define MM_PART_RST 12'h000

`endif

// ==== hw/minmax_pkg.sv ====
`include "minmax_defs.svh"

package minmax_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_PACE = 4'b0100,
    ST_AVERAGE = 4'b1000
  } mon_state_t;

  typedef enum logic [2:0] {
    SR_IDLE = 3'b001,
    SR_SET = 3'b010,
    SR_JUDGE = 3'b100
  } srch_state_t;

  typedef struct packed {
    mon_state_t st;
    logic ack;
    logic [31:0] dat;
    logic [`MM_CELLS-1:0] mask;
    logic [`MM_CELLS-1:0] part;
    logic [`MM_CELLS-1:0] eff;
    logic go;
    logic busy;
    logic [`MM_PER_CNT_W-1:0] per_cnt;
    logic [`MM_SMP_CNT_W-1:0] smp_cnt;
    logic [`MM_ACC_W-1:0] acc_hi;
    logic [`MM_ACC_W-1:0] acc_lo;
    logic [`MM_AVE_CNT_W-1:0] ave_cnt;
    logic [`MM_CODE_W-1:0] res_hi;
    logic [`MM_CODE_W-1:0] res_lo;
    logic [1:0] upd_hi;
    logic [1:0] upd_lo;
  } mon_regs_t;

  typedef struct packed {
    srch_state_t st;
    logic [`MM_IDX_W-1:0] idx;
    logic [`MM_CODE_W-1:0] keep_hi;
    logic [`MM_CODE_W-1:0] keep_lo;
    logic [`MM_CODE_W-1:0] dac_hi;
    logic [`MM_CODE_W-1:0] dac_lo;
    logic done;
  } srch_regs_t;

endpackage : minmax_pkg

// ==== hw/search_if.sv ====
`timescale 1ns/1ps
`include "minmax_defs.svh"

interface search_if;
  logic start;
  logic [`MM_CELLS-1:0] mask;
  logic done;
  logic [`MM_CODE_W-1:0] max_code;
  logic [`MM_CODE_W-1:0] min_code;

  modport ctrl (output start, output mask, input done, input max_code, input min_code);
  modport srch (input start, input mask, output done, output max_code, output min_code);
endinterface : search_if

// ==== hw/extreme_search.sv ====
`timescale 1ns/1ps
`include "minmax_defs.svh"

module extreme_search (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Control side
  search_if.srch sif,
  // Per-cell comparators against the two trial codes
  input wire logic [`MM_CELLS-1:0] cmp_above_hi,
  input wire logic [`MM_CELLS-1:0] cmp_above_lo,
  // Trial codes to the comparator references
  output logic [`MM_CODE_W-1:0] dac_hi_code,
  output logic [`MM_CODE_W-1:0] dac_lo_code
);

  localparam minmax_pkg::srch_regs_t RST = '{st: minmax_pkg::SR_IDLE, default: '0};

  minmax_pkg::srch_regs_t r;
  minmax_pkg::srch_regs_t n;
  logic [`MM_CELLS-1:0] hit_any;
  logic [`MM_CELLS-1:0] hit_all;
  logic [`MM_CODE_W-1:0] bit_hi;

  // ----------------------------------------------------------------
  // Masked comparator votes
  // ----------------------------------------------------------------
  // Disabled cells vote "no" for the max and "yes" for the min
  genvar c;
  generate
    for (c = 0; c < `MM_CELLS; c++) begin : g_vote
      assign hit_any[c] = cmp_above_hi[c] & sif.mask[c];
      assign hit_all[c] = cmp_above_lo[c] | ~sif.mask[c];
    end
  endgenerate

  always_comb begin
    n = r;
    n.done = 1'b0;
    bit_hi = `MM_CODE_W'(1) << r.idx;
    unique case (r.st)
      minmax_pkg::SR_IDLE: begin
        if (sif.start) begin
          n.keep_hi = '0;
          n.keep_lo = '0;
          n.idx = `MM_IDX_W'(`MM_CODE_W - 1);
          n.st = minmax_pkg::SR_SET;
        end
      end
      minmax_pkg::SR_SET: begin
        // Trial codes settle one cycle before they are judged
        n.dac_hi = r.keep_hi | bit_hi;
        n.dac_lo = r.keep_lo | bit_hi;
        n.st = minmax_pkg::SR_JUDGE;
      end
      minmax_pkg::SR_JUDGE: begin
        if (|hit_any) begin
          n.keep_hi = r.dac_hi;
        end
        if (&hit_all) begin
          n.keep_lo = r.dac_lo;
        end
        if (r.idx == '0) begin
          n.done = 1'b1;
          n.st = minmax_pkg::SR_IDLE;
        end else begin
          n.idx = r.idx - `MM_IDX_W'(1);
          n.st = minmax_pkg::SR_SET;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  assign sif.done = r.done;
  assign sif.max_code = r.keep_hi;
  assign sif.min_code = r.keep_lo;
  assign dac_hi_code = r.dac_hi;
  assign dac_lo_code = r.dac_lo;

endmodule : extreme_search

// ==== bench/cell_model.sv ====
`timescale 1ns/1ps
`include "minmax_defs.svh"

module cell_model (
  // Trial codes from the search
  input wire logic [`MM_CODE_W-1:0] dac_hi_code,
  input wire logic [`MM_CODE_W-1:0] dac_lo_code,
  // Cell codes, sense input minus lower cell input
  input wire logic [`MM_CELLS-1:0][`MM_CODE_W-1:0] volts,
  // Comparators
  output logic [`MM_CELLS-1:0] cmp_above_hi,
  output logic [`MM_CELLS-1:0] cmp_above_lo
);
  // Disabled cells still answer, so the design must mask them itself
  always_comb begin
    for (int i = 0; i < `MM_CELLS; i++) begin
      cmp_above_hi[i] = volts[i] >= dac_hi_code;
      cmp_above_lo[i] = volts[i] >= dac_lo_code;
    end
  end
endmodule : cell_model

// ==== bench/secondary_cell_minmax_monitor_chk.sv ====
`timescale 1ns/1ps
`include "minmax_defs.svh"

module secondary_cell_minmax_monitor_chk #(
  parameter int AVE_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Status
  input wire logic busy
);
  localparam int WIN_MIN = 15 * 64 + AVE_CYCLES;
  localparam int WIN_MAX = 17 * 64 + AVE_CYCLES;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic [31:0] busy_cnt_reg;
  always_ff @(posedge clk_sys) begin
    busy_cnt_reg <= (!rstn || !busy) ? 32'h0000_0000 : busy_cnt_reg + 32'h0000_0001;
  end
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("request not answered");
  property p_ack_req; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack without request");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_busy_start; $rose(busy) |-> $past(wb_ack_o) || $past(wb_ack_o, 2); endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy rose without access");
  property p_busy_hold; $rose(busy) |=> busy [*8]; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
  property p_busy_window; $fell(busy) |-> busy_cnt_reg >= WIN_MIN && busy_cnt_reg <= WIN_MAX; endproperty
  a_busy_window: assert property (p_busy_window) else $error("measurement length wrong");
  property p_res_fields;
    wb_ack_o && !wb_we_i && (wb_adr_i == `MM_OFS_HI || wb_adr_i == `MM_OFS_LO)
      |-> wb_dat_o[31:14] == 18'h0_0000 && !wb_dat_o[11];
  endproperty
  a_res_fields: assert property (p_res_fields) else $error("result field too wide");
  property p_ctrl_busy; wb_ack_o && !wb_we_i && wb_adr_i == `MM_OFS_CTRL && busy && $past(busy) |-> wb_dat_o[1];
  endproperty
  a_ctrl_busy: assert property (p_ctrl_busy) else $error("busy bit not shown");
  c_start: cover property ($rose(busy));
  c_done: cover property ($fell(busy));
  c_res_read: cover property (wb_ack_o && !wb_we_i && wb_adr_i == `MM_OFS_HI);
endmodule : secondary_cell_minmax_monitor_chk

bind secondary_cell_minmax_monitor secondary_cell_minmax_monitor_chk #(.AVE_CYCLES(AVE_CYCLES)) chk (
  .clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy(busy));

// ==== bench/test_secondary_cell_minmax_monitor.sv ====
`timescale 1ns/1ps
`include "minmax_defs.svh"

module test_secondary_cell_minmax_monitor;
  localparam int AVE = 20;
  logic clk_sys, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, busy;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [3:0] wb_sel_i;
  logic [11:0] cmp_hi, cmp_lo, mask, part;
  logic [10:0] dac_hi, dac_lo;
  logic [11:0][10:0] volts;
  int error_cnt, compares, cycles, upd;

  secondary_cell_minmax_monitor #(.AVE_CYCLES(AVE)) DUT (.clk_sys(clk_sys), .rstn(rstn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_above_hi(cmp_hi),
    .cmp_above_lo(cmp_lo), .dac_hi_code(dac_hi), .dac_lo_code(dac_lo), .busy(busy));
  cell_model cells (.dac_hi_code(dac_hi), .dac_lo_code(dac_lo), .volts(volts),
    .cmp_above_hi(cmp_hi), .cmp_above_lo(cmp_lo));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task end_sim;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  // Run is about 5 x 1100 cycles; ceiling leaves ample slack
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt = error_cnt + 1;
      end_sim();
    end
  end

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  // Extreme over the cells enabled at start; constant cells make the mean exact
  function automatic logic [31:0] exp_res(input bit hi, input int cnt);
    int best;
    best = hi ? -1 : 4096;
    for (int i = 0; i < 12; i++) begin
      if (mask[i] && part[i] && hi && int'(volts[i]) > best) best = volts[i];
      if (mask[i] && part[i] && !hi && int'(volts[i]) < best) best = volts[i];
    end
    return {18'h0_0000, 2'(cnt), 1'b0, 11'(best)};
  endfunction : exp_res

  initial begin
    void'($urandom(32'h6f0834df));
    {rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    volts = '0;
    {error_cnt, compares, cycles, upd} = '0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int a = 0; a <= 20; a += 4) begin
      wb(1'b0, 8'(a), 32'h0, rd);
      check("reset value", rd, 32'h0000_0000);
    end
    wb(1'b1, 8'h14, 32'hFFFF_FFFF, rd);
    wb(1'b0, 8'h14, 32'h0, rd);
    check("unmapped", rd, 32'h0000_0000);
    wb(1'b1, `MM_OFS_MASK, 32'h0000_0001, rd);
    wb(1'b1, `MM_OFS_PART, 32'h0000_0002, rd);
    wb(1'b1, `MM_OFS_CTRL, 32'h0000_0001, rd);
    wb(1'b0, `MM_OFS_CTRL, 32'h0, rd);
    check("refused start", rd, 32'h0000_0000);
    for (int run = 0; run < 5; run++) begin
      for (int i = 0; i < 12; i++) volts[i] <= 11'($urandom_range(2047));
      mask = (run == 0) ? 12'h001 << $urandom_range(11) : 12'($urandom_range(4095, 1));
      if (run == 3) begin
        volts[0] <= 11'h000;
        volts[11] <= 11'h7FF;
        mask = 12'hFFF;
      end
      part = mask | 12'($urandom);
      wb(1'b1, `MM_OFS_MASK, {20'h0_0000, mask}, rd);
      wb(1'b1, `MM_OFS_PART, {20'h0_0000, part}, rd);
      wb(1'b1, `MM_OFS_CTRL, 32'h0000_0001, rd);
      wb(1'b0, `MM_OFS_CTRL, 32'h0, rd);
      check("busy", rd, 32'h0000_0002);
      if (run == 2) begin
        wb(1'b1, `MM_OFS_CTRL, 32'h0000_0001, rd);
        wb(1'b1, `MM_OFS_MASK, {20'h0_0000, ~mask}, rd);
      end
      while (busy !== 1'b0) @(posedge clk_sys);
      upd = upd + 1;
      wb(1'b0, `MM_OFS_HI, 32'h0, rd);
      check("highest", rd, exp_res(1'b1, upd));
      wb(1'b0, `MM_OFS_LO, 32'h0, rd);
      check("lowest", rd, exp_res(1'b0, upd));
    end
    end_sim();
  end
endmodule : test_secondary_cell_minmax_monitor
